// >>> verilog/sest_top.sv
`timescale 1ns/100ps
`include "sest_map.svh"
module sest_top #(
	parameter int unsigned TICK_DIV = `SEST_TICK_DIV
) (
	input  wire logic                core_clk,
	input  wire logic                srst,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire sest_pkg::sest_pins_s pins_i,
	output logic      [1:0]          safety_out,
	output logic                     door_mon_out,
	output logic                     fault_diag_output,
	output sest_pkg::sest_leds_s     leds_o
);
	import sest_pkg::*;

	// ==========================================================
	// timing constants in base ticks
	localparam logic [11:0] SELF_T   = 12'(`SEST_MS_TICKS(`SEST_SELFTEST_MS));
	localparam logic [11:0] TEACH_T  = 12'(`SEST_MS_TICKS(`SEST_TEACH_MS));
	localparam logic [11:0] DWELL_T  = 12'(`SEST_MS_TICKS(`SEST_DWELL_MS));
	localparam logic [11:0] SETTLE_T = 12'(`SEST_MS_TICKS(`SEST_SETTLE_MS));
	localparam logic [7:0]  FRAME_T  = 8'(`SEST_MS_TICKS(`SEST_FRAME_MS));
	localparam logic [7:0]  H_SELF   = 8'(`SEST_HALF_TICKS(`SEST_SELF_HZ));
	localparam logic [7:0]  H_SETUP  = 8'(`SEST_HALF_TICKS(`SEST_SETUP_HZ));
	localparam logic [7:0]  H_TEACH  = 8'(`SEST_HALF_TICKS(`SEST_TEACH_HZ));
	localparam logic [7:0]  H_BURST  = 8'(`SEST_BURST_HALF);
	localparam logic [7:0]  BURST_END = 8'(2 * `SEST_BURST_CNT * `SEST_BURST_HALF);

	if (TICK_DIV < 2 || TICK_DIV >= (1 << `SEST_PRESC_W)) begin : g_chk
		$error("sest_top: TICK_DIV out of range for the prescaler");
	end

	// ==========================================================
	// helpers
	function automatic logic [11:0] sat_inc(input logic [11:0] v);
		return (v == 12'hfff) ? v : v + 12'h001;
	endfunction : sat_inc

	// square wave of half period h over the frame phase
	function automatic logic flash(input logic [7:0] ph, input logic [7:0] h);
		logic [7:0] slot;
		slot = ph / h;
		return slot[0] == 1'b0;
	endfunction : flash

	// byte-lane merge of a wishbone write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// ==========================================================
	// pins into the clock domain
	sest_pins_s p;

	sest_sync #(
		.W ($bits(sest_pins_s))
	) u_sync (
		.core_clk (core_clk),
		.srst     (srst),
		.async_in (pins_i),
		.sync_out (p)
	);

	sest_top_s q_q;
	sest_top_s q_d;

	// ==========================================================
	// derived views of configuration and live inputs
	logic [5:0] live_snap;
	logic [3:0] chan_t;
	logic       man_t;
	logic       fb_t;
	logic       all_closed;
	logic [3:0] door_rise;
	logic [3:0] door_fall;
	logic       jumper_rise;
	logic       cfg_live_bad;
	logic [7:0] cfg_live_cause;
	logic       hard_fault;

	always_comb begin
		live_snap   = {p.function_test_input, p.start_in, p.door_closed};
		chan_t      = q_q.taught[3:0];
		man_t       = q_q.taught[`SEST_SW_MANUAL_BIT];
		fb_t        = q_q.taught[`SEST_SW_FB_BIT];
		all_closed  = ((p.door_closed & chan_t) == chan_t);
		door_rise   = p.door_closed & ~q_q.doors_prev & chan_t;
		door_fall   = ~p.door_closed & q_q.doors_prev & chan_t;
		jumper_rise = p.teach_jumper_terminals & ~q_q.jumper_prev;
		// checks that hold while a taught configuration runs
		cfg_live_cause    = 8'h00;
		cfg_live_cause[3] = (p.cfg_sw != q_q.taught[5:0]);
		cfg_live_cause[4] = jumper_rise;
		cfg_live_cause[5] = p.feedback_loop_terminals & ~fb_t;
		cfg_live_cause[6] = p.start_in & ~man_t;
		cfg_live_bad      = (cfg_live_cause != 8'h00);
		// hard faults: internal fault, welded contact (relay still reads closed once the drive has settled off), open feedback loop, short dwell
		hard_fault = p.internal_fault
			| ((q_q.safety == 2'b00) && (q_q.settle >= SETTLE_T) && (p.relay_readback != 2'b00))
			| (fb_t && (q_q.safety == 2'b00) && (q_q.settle >= SETTLE_T)
				&& !p.feedback_loop_terminals)
			| ((door_fall != 4'h0) && (q_q.dwell < DWELL_T));
	end

	// ==========================================================
	// next-state logic
	always_comb begin
		q_d     = q_q;
		q_d.ack = 1'b0;

		// base tick from the programmable prescaler
		q_d.tick = 1'b0;
		if (q_q.div_cnt + 20'h00001 >= q_q.presc) begin
			q_d.div_cnt = 20'h00000;
			q_d.tick    = 1'b1;
		end else begin
			q_d.div_cnt = q_q.div_cnt + 20'h00001;
		end
		if (q_q.tick) begin
			q_d.phase  = (q_q.phase + 8'h01 >= FRAME_T) ? 8'h00 : q_q.phase + 8'h01;
			q_d.timer  = sat_inc(q_q.timer);
			q_d.dwell  = sat_inc(q_q.dwell);
			q_d.settle = sat_inc(q_q.settle);
		end
		if (door_rise != 4'h0) begin
			q_d.dwell = 12'h000;
		end
		q_d.jumper_prev = p.teach_jumper_terminals;
		q_d.doors_prev  = p.door_closed;

		// outputs default to the safe, dark condition
		q_d.safety   = 2'b00;
		q_d.door_mon = 1'b0;
		q_d.diag     = 1'b0;
		q_d.leds     = '0;

		case (q_q.state)
			ST_SELF: begin
				// relays off and monitors low for the ready delay
				q_d.leds.green = flash(q_q.phase, H_SELF);
				if (q_q.timer >= SELF_T) begin
					q_d.timer = 12'h000;
					if (p.teach_jumper_terminals) begin
						q_d.state = ST_TEACH;
						q_d.snap  = live_snap;
						q_d.cause[1] = (p.cfg_sw[3:0] == 4'h0);
						q_d.cause[2] = (p.door_closed != p.cfg_sw[3:0])
							| (p.cfg_sw[`SEST_SW_MANUAL_BIT] & ~p.start_in)
							| (p.cfg_sw[`SEST_SW_FB_BIT] & ~p.feedback_loop_terminals);
						if ((p.cfg_sw[3:0] == 4'h0) || (p.door_closed != p.cfg_sw[3:0])
							|| (p.cfg_sw[`SEST_SW_MANUAL_BIT] && !p.start_in)
							|| (p.cfg_sw[`SEST_SW_FB_BIT] && !p.feedback_loop_terminals)) begin
							q_d.state = ST_CFG;
						end
					end else if (!q_q.taught[`SEST_VALID_BIT]) begin
						q_d.state = ST_SETUP;
					end else begin
						q_d.state = ST_RUN;
					end
				end
			end
			ST_SETUP: begin
				q_d.leds.green = flash(q_q.phase, H_SETUP);
				if (jumper_rise) begin
					q_d.cause[4] = 1'b1;
					q_d.state    = ST_CFG;
				end
			end
			ST_TEACH: begin
				q_d.leds.green = flash(q_q.phase, H_TEACH);
				if (live_snap != q_q.snap) begin
					q_d.cause[0] = 1'b1;
					q_d.state    = ST_CFG;
				end else if (q_q.timer >= TEACH_T) begin
					// done flag sits at bit 8, two spare bits above the switch field
					q_d.capt  = {1'b1, 2'b00, p.cfg_sw};
					q_d.state = ST_TDONE;
				end
			end
			ST_TDONE: begin
				// everything dark until the supply is cycled
				q_d.leds = '0;
			end
			ST_RUN: begin
				q_d.leds.green = 1'b1;
				q_d.door_mon   = all_closed;
				// manual start: arm only on a press with every door closed
				if (!all_closed) begin
					q_d.armed = 1'b0;
				end else if (p.start_in) begin
					q_d.armed = 1'b1;
				end
				// with a feedback loop, switch on only while the loop is closed
				if (all_closed && (!man_t || q_q.armed)
					&& (q_q.safety != 2'b00 || !fb_t || p.feedback_loop_terminals)) begin
					q_d.safety = 2'b11;
				end
				if (hard_fault) begin
					q_d.state  = ST_FAULT;
					q_d.safety = 2'b00;
					q_d.cause[7] = 1'b1;
				end else if (cfg_live_bad) begin
					q_d.state  = ST_CFG;
					q_d.safety = 2'b00;
					q_d.cause  = q_q.cause | cfg_live_cause;
				end else if (p.function_test_input) begin
					q_d.state  = ST_FTEST;
					q_d.safety = 2'b00;
					q_d.armed  = 1'b0;
				end
				if (q_d.safety != q_q.safety) begin
					q_d.settle = 12'h000;
				end
				// yellow follows the final drive, so a fault in this cycle never shows it
				q_d.leds.yellow = (q_d.safety == 2'b11);
			end
			ST_FTEST: begin
				// simulated opening: outputs off, diagnostics raised
				q_d.safety      = 2'b00;
				q_d.diag        = 1'b1;
				q_d.leds.green  = 1'b1;
				q_d.leds.red    = 1'b1;
				q_d.armed       = 1'b0;
				if (p.internal_fault) begin
					q_d.state    = ST_FAULT;
					q_d.cause[7] = 1'b1;
				end else if (!p.function_test_input) begin
					q_d.state     = ST_RUN;
					q_d.diag      = 1'b0;
					q_d.leds.red  = 1'b0;
				end
			end
			ST_FAULT: begin
				// latched until power is cycled
				q_d.diag     = 1'b1;
				q_d.leds.red = 1'b1;
			end
			ST_CFG: begin
				// three short flashes at the start of each one-second frame
				q_d.diag       = 1'b1;
				q_d.leds.red   = 1'b1;
				q_d.leds.green = (q_q.phase < BURST_END) && flash(q_q.phase, H_BURST);
			end
			default: begin
				q_d.state = ST_FAULT;
			end
		endcase

		// wishbone classic slave: one-cycle ack, unmapped reads zero
		if (wb_cyc_i && wb_stb_i && !q_q.ack) begin
			q_d.ack = 1'b1;
			q_d.dat = 32'h00000000;
			if (wb_we_i) begin
				case (wb_adr_i)
					`SEST_ADR_PRESC: begin
						q_d.presc = 20'(merge({12'h000, q_q.presc}, wb_dat_i, wb_sel_i));
					end
					`SEST_ADR_TAUGHT: begin
						q_d.taught = 9'(merge({23'h000000, q_q.taught}, wb_dat_i, wb_sel_i));
					end
					default: begin
						q_d.dat = 32'h00000000;
					end
				endcase
			end else begin
				case (wb_adr_i)
					`SEST_ADR_PRESC:  q_d.dat = {12'h000, q_q.presc};
					`SEST_ADR_TAUGHT: q_d.dat = {23'h000000, q_q.taught};
					`SEST_ADR_STATUS: q_d.dat = {16'h0000, q_q.cause, q_q.state};
					`SEST_ADR_CAPT:   q_d.dat = {23'h000000, q_q.capt};
					`SEST_ADR_PINS:   q_d.dat = {15'h0000, p};
					default:          q_d.dat = 32'h00000000;
				endcase
			end
		end
	end

	// ==========================================================
	// state register; reset is power-on and starts the self-test
	always_ff @(posedge core_clk) begin
		if (srst) begin
			q_q        <= '0;
			q_q.state  <= ST_SELF;
			q_q.presc  <= TICK_DIV[19:0];
			q_q.taught <= `SEST_TAUGHT_RST;
		end else begin
			q_q <= q_d;
		end
	end

	// outputs straight from the state flops
	assign wb_dat_o          = q_q.dat;
	assign wb_ack_o          = q_q.ack;
	assign safety_out        = q_q.safety;
	assign door_mon_out      = q_q.door_mon;
	assign fault_diag_output = q_q.diag;
	assign leds_o            = q_q.leds;
endmodule : sest_top

// >>> verilog/sest_map.svh
`ifndef SEST_MAP_SVH
`define SEST_MAP_SVH
// ==========================================================
// register offsets (byte addresses, one word each)
`define SEST_ADR_PRESC      8'h00
`define SEST_ADR_TAUGHT     8'h04
`define SEST_ADR_STATUS     8'h08
`define SEST_ADR_CAPT       8'h0c
`define SEST_ADR_PINS       8'h10
// ==========================================================
// field positions and reset values
`define SEST_VALID_BIT      8
`define SEST_SW_MANUAL_BIT  4
`define SEST_SW_FB_BIT      5
`define SEST_STATE_LSB      0
`define SEST_CAUSE_LSB      8
`define SEST_TAUGHT_RST     9'h000
`define SEST_PRESC_W        20
// ==========================================================
// timing: clock, base tick and durations in their own units
`define SEST_CLK_HZ         100000000
`define SEST_TICK_HZ        120
`define SEST_TICK_DIV       (`SEST_CLK_HZ / `SEST_TICK_HZ)
`define SEST_SELFTEST_MS    10000
`define SEST_TEACH_MS       10000
`define SEST_DWELL_MS       500
`define SEST_SETTLE_MS      100
`define SEST_FRAME_MS       1000
`define SEST_MS_TICKS(ms)   (((ms) * `SEST_TICK_HZ + 999) / 1000)
`define SEST_HALF_TICKS(hz) (`SEST_TICK_HZ / (2 * (hz)))
`define SEST_SELF_HZ        15
`define SEST_SETUP_HZ       4
`define SEST_TEACH_HZ       1
`define SEST_BURST_HALF     8
`define SEST_BURST_CNT      3
`endif

// >>> verilog/sest_pkg.sv
package sest_pkg;
	// ==========================================================
	// one-hot top states
	typedef enum logic [7:0] {
		ST_SELF  = 8'h01,
		ST_SETUP = 8'h02,
		ST_TEACH = 8'h04,
		ST_TDONE = 8'h08,
		ST_RUN   = 8'h10,
		ST_FTEST = 8'h20,
		ST_FAULT = 8'h40,
		ST_CFG   = 8'h80
	} sest_state_e;

	// pins after synchronisation
	typedef struct packed {
		logic       function_test_input;
		logic       start_in;
		logic       feedback_loop_terminals;
		logic       teach_jumper_terminals;
		logic [3:0] door_closed;
		logic [1:0] relay_readback;
		logic       internal_fault;
		logic [5:0] cfg_sw;
	} sest_pins_s;

	typedef struct packed {
		logic green;
		logic yellow;
		logic red;
	} sest_leds_s;

	// whole state of the top module
	typedef struct packed {
		sest_state_e state;
		logic [19:0] presc;
		logic [8:0]  taught;
		logic [8:0]  capt;
		logic [7:0]  cause;
		logic [19:0] div_cnt;
		logic        tick;
		logic [7:0]  phase;
		logic [11:0] timer;
		logic [11:0] dwell;
		logic [11:0] settle;
		logic [5:0]  snap;
		logic        jumper_prev;
		logic [3:0]  doors_prev;
		logic        armed;
		logic [1:0]  safety;
		logic        door_mon;
		logic        diag;
		sest_leds_s  leds;
		logic        ack;
		logic [31:0] dat;
	} sest_top_s;
endpackage : sest_pkg

// >>> verilog/sest_sync.sv
`timescale 1ns/100ps
// ==========================================================
// three-stage pin synchroniser; a bit changes once stages two and three agree
module sest_sync #(
	parameter int unsigned W = 17
) (
	input  wire logic         core_clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sest_sync_s;

	sest_sync_s q_q;
	sest_sync_s q_d;

	if (W < 1) begin : g_chk
		$error("sest_sync: W must be at least 1");
	end

	// s1 feeds only s2; the agreement test looks at s2 and s3
	always_comb begin
		q_d    = q_q;
		q_d.s1 = async_in;
		q_d.s2 = q_q.s1;
		q_d.s3 = q_q.s2;
		q_d.q  = (~(q_q.s2 ^ q_q.s3) & q_q.s3) | ((q_q.s2 ^ q_q.s3) & q_q.q);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			q_q <= '0;
		end else begin
			q_q <= q_d;
		end
	end

	assign sync_out = q_q.q;
endmodule : sest_sync

// >>> verification/sest_plant.sv
`timescale 1ns/100ps
// ==========
// machine side: doors, start button, test input and relay contacts
module sest_plant
	import sest_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire sest_pkg::sest_pins_s cmd,
	input  wire logic                 weld,
	input  wire logic [1:0]           safety_out,
	output sest_pkg::sest_pins_s      pins
);
	logic [1:0] contact_q;

	// contacts follow the drive a cycle late; a welded pair never opens
	always_ff @(posedge core_clk) begin
		contact_q <= safety_out | {2{weld}};
	end

	// test input and start button come straight from the bench
	always_comb begin
		pins = cmd;
		pins.relay_readback = contact_q;
	end
endmodule : sest_plant

// >>> verification/sest_top_props.sv
`timescale 1ns/100ps
// ==========
// output relations seen at the pins of the block
module sest_top_props
	import sest_pkg::*;
#(
	parameter int unsigned TICK_DIV = 4
) (
	input wire logic                 core_clk,
	input wire logic                 srst,
	input wire logic                 wb_cyc_i,
	input wire logic                 wb_stb_i,
	input wire logic                 wb_we_i,
	input wire logic [7:0]           wb_adr_i,
	input wire logic [3:0]           wb_sel_i,
	input wire logic [31:0]          wb_dat_i,
	input wire logic [31:0]          wb_dat_o,
	input wire logic                 wb_ack_o,
	input wire sest_pkg::sest_pins_s pins_i,
	input wire logic [1:0]           safety_out,
	input wire logic                 door_mon_out,
	input wire logic                 fault_diag_output,
	input wire sest_pkg::sest_leds_s leds_o
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	// ==========
	// safety outputs and indicators
	property p_reset_quiet;
		$past(srst) |-> safety_out == 2'b00 && !fault_diag_output && !door_mon_out && !leds_o.red && !leds_o.yellow;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
	property p_diag_safe;
		fault_diag_output |-> safety_out == 2'b00;
	endproperty
	a_diag_safe: assert property (p_diag_safe) else $error("relays closed with diag high");
	property p_red_diag;
		leds_o.red == fault_diag_output;
	endproperty
	a_red_diag: assert property (p_red_diag) else $error("red and diag disagree");
	property p_yellow_closed;
		leds_o.yellow |-> safety_out == 2'b11 && leds_o.green && !leds_o.red;
	endproperty
	a_yellow_closed: assert property (p_yellow_closed) else $error("yellow without closed circuit");
	// a test pulse held six cycles must open the circuit within three more
	property p_ftest_on;
		$rose(pins_i.function_test_input) && safety_out == 2'b11 ##1 pins_i.function_test_input [*5]
			|-> ##[0:3] (safety_out == 2'b00 && fault_diag_output && leds_o.green && !leds_o.yellow);
	endproperty
	a_ftest_on: assert property (p_ftest_on) else $error("function test not shown");
	property p_ftest_off;
		$fell(pins_i.function_test_input) && fault_diag_output && leds_o.green
			|-> ##[3:9] (!fault_diag_output && !leds_o.red);
	endproperty
	a_ftest_off: assert property (p_ftest_off) else $error("function test not released");
	property p_fault_latch;
		leds_o.red && !leds_o.green |=> leds_o.red;
	endproperty
	a_fault_latch: assert property (p_fault_latch) else $error("fault display dropped");
	// ==========
	// register bus handshake
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_answer;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
endmodule : sest_top_props

bind sest_top sest_top_props #(.TICK_DIV(TICK_DIV)) u_props (.core_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pins_i, .safety_out, .door_mon_out,
	.fault_diag_output, .leds_o);

// >>> verification/sest_top_test.sv
`timescale 1ns/100ps
module sest_top_test;
	import sest_pkg::*;
	// ==========
	// bench signals; a short prescaler keeps the ten second counts small
	localparam int unsigned DIV = 4;
	logic        core_clk, srst, cyc, stb, we, weld, ack;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rd_o, rdat;
	logic [1:0]  safety_out;
	logic        door_mon_out, fault_diag_output;
	sest_leds_s  leds_o;
	sest_pins_s  cmd, pins;
	int          n_fail, checks, ticks, t0, e, i;

	sest_top #(.TICK_DIV(DIV)) uut (.core_clk, .srst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd_o), .wb_ack_o(ack), .pins_i(pins),
		.safety_out, .door_mon_out, .fault_diag_output, .leds_o);
	sest_plant plant (.core_clk, .cmd, .weld, .safety_out, .pins);

	// ==========
	// clock and hang guard
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		ticks++;
		if (ticks == 100000) begin
			n_fail++;
			summarize();
		end
	end

	// ==========
	// helpers
	task automatic summarize();
		$display("checks %0d fails %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// outputs packed as green, yellow, red, relays, diag
	task automatic look(input logic [5:0] x, input logic [5:0] m = 6'h3f);
		chk({26'h0, {leds_o, safety_out, fault_diag_output} & m}, {26'h0, x});
	endtask : look
	// entered just after an edge; the request stands until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge core_clk); while (ack !== 1'b1);
		rdat = rd_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge core_clk);
	endtask : wb
	task automatic flashes(input int n);
		logic g;
		e = 0;
		g = leds_o.green;
		repeat (n) begin
			@(posedge core_clk);
			if (leds_o.green !== g)
				e++;
			g = leds_o.green;
		end
	endtask : flashes
	// power-on: pins applied through reset, stored config written at once
	task automatic boot(input sest_pins_s p, input logic [31:0] t);
		cmd <= p;
		weld <= 1'b0;
		srst <= 1'b1;
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		t0 = ticks;
		@(posedge core_clk);
		wb(1'b1, 8'h04, t);
	endtask : boot
	task automatic leave(input logic [7:0] s);
		int n;
		n = 0;
		do begin
			wb(1'b0, 8'h08, 32'h0);
			n++;
		end while (rdat[7:0] === s && n < 3000);
	endtask : leave
	function automatic sest_pins_s mk(input logic j, s, f, input logic [3:0] d, input logic [5:0] w);
		mk = '{1'b0, s, f, j, d, 2'b00, 1'b0, w};
	endfunction : mk
	task automatic hold(input int n);
		repeat (n) @(posedge core_clk);
	endtask : hold

	// ==========
	// scenarios
	task automatic t_boot();
		boot(mk(0, 0, 0, 4'h0, 6'h00), 32'h0);
		look(6'h00, 6'h1f);
		wb(1'b0, 8'h00, 32'h0);
		chk(rdat, DIV);
		wb(1'b1, 8'h20, 32'hffff_ffff);
		wb(1'b0, 8'h20, 32'h0);
		chk(rdat, 32'h0);
		flashes(320);
		chk(e >= 19 && e <= 21, 1);
		leave(8'h01);
		chk(ticks - t0 > 4780 && ticks - t0 < 4830, 1);
		chk(rdat[7:0], 8'h02);
		flashes(600);
		chk(e >= 9 && e <= 11, 1);
		look(6'h00, 6'h1f);
		cmd.teach_jumper_terminals <= 1'b1;
		hold(20);
		wb(1'b0, 8'h08, 32'h0);
		chk(rdat & 32'h10ff, 32'h1080);
		look(6'h09, 6'h1f);
		flashes(480);
		chk(e >= 5 && e <= 7, 1);
		$display("boot and setup done");
	endtask : t_boot
	task automatic t_teach();
		boot(mk(1, 1, 1, 4'h3, 6'h33), 32'h0);
		leave(8'h01);
		chk(rdat[7:0], 8'h04);
		flashes(960);
		chk(e >= 3 && e <= 5, 1);
		look(6'h00, 6'h1f);
		leave(8'h04);
		chk(rdat[7:0], 8'h08);
		look(6'h00);
		wb(1'b0, 8'h0c, 32'h0);
		chk(rdat & 32'h13f, 32'h133);
		$display("teach done");
	endtask : t_teach
	task automatic t_run();
		boot(mk(0, 0, 0, 4'h3, 6'h03), 32'h103);
		leave(8'h01);
		hold(20);
		look(6'h36);
		chk(door_mon_out, 1);
		cmd.door_closed <= 4'h2;
		hold(20);
		look(6'h20);
		chk(door_mon_out, 0);
		cmd.door_closed <= 4'h3;
		hold(300);
		cmd.function_test_input <= 1'b1;
		hold(10);
		look(6'h29);
		cmd.function_test_input <= 1'b0;
		hold(10);
		look(6'h36);
		$display("run done");
	endtask : t_run
	// welded contact, short dwell, internal failure, feedback loop left open
	task automatic t_fault(input int m);
		boot(mk(0, 0, m == 3, 4'h3, (m == 3) ? 6'h23 : 6'h03), (m == 3) ? 32'h123 : 32'h103);
		leave(8'h01);
		weld <= (m == 0);
		cmd.internal_fault <= (m == 2);
		cmd.feedback_loop_terminals <= 1'b0;
		if (m == 1) begin
			cmd.door_closed <= 4'h2;
			hold(300);
			cmd.door_closed <= 4'h3;
			hold(100);
		end
		cmd.door_closed <= 4'h2;
		hold(100);
		cmd.door_closed <= 4'h3;
		hold(300);
		look(6'h09);
		wb(1'b0, 8'h08, 32'h0);
		chk(rdat[7:0], 8'h40);
		$display("fault %0d done", m);
	endtask : t_fault
	task automatic t_manual();
		boot(mk(0, 0, 0, 4'h3, 6'h13), 32'h113);
		leave(8'h01);
		hold(20);
		look(6'h20);
		cmd.start_in <= 1'b1;
		hold(10);
		cmd.start_in <= 1'b0;
		hold(10);
		look(6'h36);
		$display("manual done");
	endtask : t_manual
	// the doors are set to 4'h1 in every case; only in teach-in does it matter
	task automatic t_cfg(input sest_pins_s p, input logic [31:0] t, input logic [7:0] c);
		boot(p, t);
		leave(8'h01);
		hold(100);
		cmd.door_closed <= 4'h1;
		hold(100);
		wb(1'b0, 8'h08, 32'h0);
		chk(rdat[15:0] & {c, 8'hff}, {c, 8'h80});
		look(6'h09, 6'h1f);
		$display("config case %h done", c);
	endtask : t_cfg

	// ==========
	// main sequence
	initial begin
		srst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'hf;
		wdat = 32'h0;
		cmd = '0;
		weld = 1'b0;
		@(posedge core_clk);
		t_boot();
		t_teach();
		t_run();
		for (i = 0; i < 4; i++)
			t_fault(i);
		t_manual();
		t_cfg(mk(1, 0, 0, 4'h3, 6'h03), 32'h0, 8'h01);
		t_cfg(mk(1, 0, 0, 4'h3, 6'h00), 32'h0, 8'h02);
		t_cfg(mk(1, 0, 0, 4'h1, 6'h03), 32'h0, 8'h04);
		t_cfg(mk(0, 0, 0, 4'h7, 6'h07), 32'h103, 8'h08);
		t_cfg(mk(0, 0, 1, 4'h3, 6'h03), 32'h103, 8'h20);
		t_cfg(mk(0, 1, 0, 4'h3, 6'h03), 32'h103, 8'h40);
		summarize();
	end
endmodule : sest_top_test
